// file: hdl/hbpc_pkg.sv
// Constants, register map and carrier types of the bridge protection block
package hbpc_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register indices on the plain register port
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MASK   = 4'h1;
  localparam logic [ADDR_W-1:0] REG_FAULT  = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STATE  = 4'h3;

  // Event bits, shared by status and mask registers
  localparam int unsigned NUM_EV = 4;
  localparam int unsigned EV_UV  = 0;
  localparam int unsigned EV_OV  = 1;
  localparam int unsigned EV_TSD = 2;
  localparam int unsigned EV_OC  = 3;
  localparam logic [NUM_EV-1:0] MASK_RST = 4'h0;

  // Power transistors with their own current monitor
  localparam int unsigned NUM_TR = 4;
  // Pin vector: dir a, dir b, uv, ov, ot, then current monitors
  localparam int unsigned PIN_A  = 0;
  localparam int unsigned PIN_B  = 1;
  localparam int unsigned PIN_UV = 2;
  localparam int unsigned PIN_OV = 3;
  localparam int unsigned PIN_OT = 4;
  localparam int unsigned PIN_OC = 5;
  localparam int unsigned NUM_PIN = PIN_OC + NUM_TR;

  // Timebase and filter times
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned OC_FILT_NS   = 5100;
  // Least time, so round up to whole cycles
  localparam int unsigned OC_FILT_CYC  = (OC_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DEAD_CYC_DEF = 32;

  // Gate enables of one leg and of the whole bridge
  typedef struct packed {
    logic hi;
    logic lo;
  } hbpc_leg_t;

  typedef struct packed {
    hbpc_leg_t a;
    hbpc_leg_t b;
  } hbpc_gates_t;

  localparam hbpc_leg_t LEG_OFF  = 2'h0;
  localparam hbpc_leg_t LEG_HIGH = 2'h2;
  localparam hbpc_leg_t LEG_LOW  = 2'h1;

  // Bridge mode, one-hot
  typedef enum logic [3:0] {
    MODE_STOP    = 4'h1,
    MODE_FORWARD = 4'h2,
    MODE_REVERSE = 4'h4,
    MODE_BRAKE   = 4'h8
  } hbpc_mode_t;

endpackage : hbpc_pkg

// file: hdl/hbpc_top.sv
// Full-bridge decode, dead time, protection latches and register port
//
// Function
// - Both high brakes low, mixed inputs drive one direction, both low floats.
// - Undervoltage indication turns every output transistor off.
// - Undervoltage lockout releases by itself when the indication clears.
// - Overvoltage indication turns every output transistor off.
// - Overvoltage shutdown releases by itself when the indication clears.
// - Over-temperature indication turns every output transistor off.
// - Thermal and overcurrent shutdowns latch until both inputs are low.
// - Each of the four transistors has its own overcurrent monitor.
// - Overcurrent trips only after persisting longer than the filter time.
// - Host toggles between drive and short brake for speed control.
// - Dead time inserted at every leg switch, never both transistors on.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module hbpc_top
  import hbpc_pkg::*;
#(
  parameter int unsigned DEAD_CYC = DEAD_CYC_DEF,
  parameter int unsigned OC_CYC   = OC_FILT_CYC
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              dir_in_a_i,
  input  wire logic              dir_in_b_i,
  input  wire logic              undervoltage_i,
  input  wire logic              overvoltage_i,
  input  wire logic              overtemp_i,
  input  wire logic [NUM_TR-1:0] overcurrent_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  output hbpc_gates_t            gate_o,
  output logic                   irq_o
);

  localparam int unsigned DT_W = $clog2(DEAD_CYC + 1);
  localparam int unsigned OC_W = $clog2(OC_CYC + 1);
  localparam logic [DT_W-1:0] DT_LOAD = DT_W'(DEAD_CYC);
  localparam logic [OC_W-1:0] OC_TRIP = OC_W'(OC_CYC);

  // Reset release through two flops; assertion is immediate
  logic rst_meta_b_r;
  logic rst_sync_b_r;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_b_r <= 1'b0;
      rst_sync_b_r <= 1'b0;
    end else begin
      rst_meta_b_r <= 1'b1;
      rst_sync_b_r <= rst_meta_b_r;
    end
  end

  // Checks run on the one clock and rest while the reset copy is low
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_sync_b_r);

  // Pin synchronisers and agreement filter
  logic [NUM_PIN-1:0] pin_raw;
  logic [NUM_PIN-1:0] pin_s1_r;
  logic [NUM_PIN-1:0] pin_s2_r;
  logic [NUM_PIN-1:0] pin_s3_r;
  logic [NUM_PIN-1:0] pin_f_r;
  assign pin_raw = {overcurrent_i, overtemp_i, overvoltage_i,
                    undervoltage_i, dir_in_b_i, dir_in_a_i};

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PIN; gp++) begin : g_pin
      // First flop feeds only the second; a glitch must agree twice
      always_ff @(posedge sys_clk_i or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
          pin_s1_r[gp] <= 1'b0;
          pin_s2_r[gp] <= 1'b0;
          pin_s3_r[gp] <= 1'b0;
          pin_f_r[gp]  <= 1'b0;
        end else begin
          pin_s1_r[gp] <= pin_raw[gp];
          pin_s2_r[gp] <= pin_s1_r[gp];
          pin_s3_r[gp] <= pin_s2_r[gp];
          if (pin_s2_r[gp] == pin_s3_r[gp]) begin
            pin_f_r[gp] <= pin_s3_r[gp];
          end
        end
      end
    end
  endgenerate

  // Filtered views of the pins
  wire logic              dir_a    = pin_f_r[PIN_A];
  wire logic              dir_b    = pin_f_r[PIN_B];
  wire logic              uv_f     = pin_f_r[PIN_UV];
  wire logic              ov_f     = pin_f_r[PIN_OV];
  wire logic              ot_f     = pin_f_r[PIN_OT];
  wire logic [NUM_TR-1:0] oc_f     = pin_f_r[PIN_OC +: NUM_TR];
  wire logic              oc_any   = |oc_f;
  wire logic              stop_req = !dir_a && !dir_b;

  // Overcurrent persistence filter, restarts on any gap
  logic [OC_W-1:0] oc_cnt_r;
  wire logic       oc_trip = oc_any && (oc_cnt_r == OC_TRIP);

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      oc_cnt_r <= '0;
    end else if (!oc_any) begin
      oc_cnt_r <= '0;
    end else if (oc_cnt_r != OC_TRIP) begin
      oc_cnt_r <= oc_cnt_r + 1'b1;
    end
  end

  // Latched shutdowns; a new trip wins over the release
  logic tsd_r;
  logic ocl_r;

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      tsd_r <= 1'b0;
    end else if (ot_f) begin
      tsd_r <= 1'b1;
    end else if (stop_req) begin
      tsd_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      ocl_r <= 1'b0;
    end else if (oc_trip) begin
      ocl_r <= 1'b1;
    end else if (stop_req) begin
      ocl_r <= 1'b0;
    end
  end

  // Supply faults follow their indications, so release is automatic
  wire logic fault_any = uv_f || ov_f || tsd_r || ocl_r;

  // Mode follows the inputs; a fault forces stop
  hbpc_mode_t mode_r;
  hbpc_mode_t mode_nxt;
  always_comb begin
    if (fault_any) begin
      mode_nxt = MODE_STOP;
    end else if (dir_a && dir_b) begin
      mode_nxt = MODE_BRAKE;
    end else if (dir_a) begin
      mode_nxt = MODE_FORWARD;
    end else if (dir_b) begin
      mode_nxt = MODE_REVERSE;
    end else begin
      mode_nxt = MODE_STOP;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      mode_r <= MODE_STOP;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Wanted leg states; fault cuts straight through, not via mode
  hbpc_leg_t leg_want [2];
  always_comb begin
    case (mode_r)
      MODE_FORWARD: begin
        leg_want[0] = LEG_HIGH;
        leg_want[1] = LEG_LOW;
      end
      MODE_REVERSE: begin
        leg_want[0] = LEG_LOW;
        leg_want[1] = LEG_HIGH;
      end
      MODE_BRAKE: begin
        leg_want[0] = LEG_LOW;
        leg_want[1] = LEG_LOW;
      end
      default: begin
        leg_want[0] = LEG_OFF;
        leg_want[1] = LEG_OFF;
      end
    endcase
    if (fault_any) begin
      leg_want[0] = LEG_OFF;
      leg_want[1] = LEG_OFF;
    end
  end

  // Per-leg dead time: off first, wait, then turn the new side on.
  // Turning off never waits, so faults act on the next edge.
  hbpc_leg_t       leg_r  [2];
  logic [DT_W-1:0] dt_cnt_r [2];
  genvar gl;
  generate
    for (gl = 0; gl < 2; gl++) begin : g_leg
      always_ff @(posedge sys_clk_i or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
          leg_r[gl]    <= LEG_OFF;
          dt_cnt_r[gl] <= '0;
        end else if (leg_r[gl] != LEG_OFF &&
                     leg_r[gl] != leg_want[gl]) begin
          leg_r[gl]    <= LEG_OFF;
          dt_cnt_r[gl] <= DT_LOAD;
        end else if (dt_cnt_r[gl] != '0) begin
          dt_cnt_r[gl] <= dt_cnt_r[gl] - 1'b1;
        end else if (leg_r[gl] == LEG_OFF) begin
          leg_r[gl]    <= leg_want[gl];
        end
      end

      // Both gates of a leg are never on at once
      chk_no_shoot_through: assert property (
        !(leg_r[gl].hi && leg_r[gl].lo))
        else $error("leg drives both gates");
      // A gate that opens is followed by a closed gap
      sequence s_leg_release;
        $fell(leg_r[gl].hi) || $fell(leg_r[gl].lo);
      endsequence
      sequence s_leg_gap;
        (leg_r[gl] == LEG_OFF) [*2];
      endsequence
      chk_dead_gap_held: assert property (
        s_leg_release |-> s_leg_gap)
        else $error("dead time gap too short");
      // An active leg shows the decoded want of the cycle before
      chk_leg_decode_match: assert property (
        leg_r[gl] != LEG_OFF |-> $past(leg_want[gl]) == leg_r[gl])
        else $error("leg state not from decode");
    end
  endgenerate

  assign gate_o = {leg_r[0], leg_r[1]};

  // Events: rising fault indications and fresh latch trips
  logic [NUM_EV-1:0] ev;
  logic              uv_d_r;
  logic              ov_d_r;
  always_ff @(posedge sys_clk_i or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      uv_d_r <= 1'b0;
      ov_d_r <= 1'b0;
    end else begin
      uv_d_r <= uv_f;
      ov_d_r <= ov_f;
    end
  end

  always_comb begin
    ev         = '0;
    ev[EV_UV]  = uv_f && !uv_d_r;
    ev[EV_OV]  = ov_f && !ov_d_r;
    ev[EV_TSD] = ot_f && !tsd_r;
    ev[EV_OC]  = oc_trip && !ocl_r;
  end

  // Status is write-one-to-clear; a same-cycle event still sets
  logic [NUM_EV-1:0] status_r;
  logic [NUM_EV-1:0] mask_r;
  logic              irq_r;
  wire logic         wr_status = wr_i && (addr_i == REG_STATUS);
  wire logic         wr_mask   = wr_i && (addr_i == REG_MASK);

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      status_r <= '0;
    end else if (wr_status) begin
      status_r <= (status_r & ~wdata_i[NUM_EV-1:0]) | ev;
    end else begin
      status_r <= status_r | ev;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      mask_r <= MASK_RST;
    end else if (wr_mask) begin
      mask_r <= wdata_i[NUM_EV-1:0];
    end
  end

  // Level interrupt, one cycle behind status so it leaves a flop
  always_ff @(posedge sys_clk_i or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  assign irq_o = irq_r;

  // Read data for one cycle only; unmapped and idle read as zero
  logic [DATA_W-1:0] rdata_r;

  always_ff @(posedge sys_clk_i or negedge rst_sync_b_r) begin
    if (!rst_sync_b_r) begin
      rdata_r <= '0;
    end else if (!rd_i) begin
      rdata_r <= '0;
    end else if (addr_i == REG_STATUS) begin
      rdata_r <= DATA_W'(status_r);
    end else if (addr_i == REG_MASK) begin
      rdata_r <= DATA_W'(mask_r);
    end else if (addr_i == REG_FAULT) begin
      rdata_r <= DATA_W'({ocl_r, tsd_r, ov_f, uv_f});
    end else if (addr_i == REG_STATE) begin
      rdata_r <= {mode_r, gate_o};
    end else begin
      rdata_r <= '0;
    end
  end

  assign rdata_o = rdata_r;

  // Protection and decode checks; clock and reset from the defaults
  sequence s_supply_clean;
    !uv_f && !ov_f && !tsd_r && !ocl_r;
  endsequence
  chk_uv_gates_off: assert property (
    uv_f |=> gate_o == '0)
    else $error("gates on during undervoltage");
  chk_uv_self_release: assert property (
    (uv_f ##1 s_supply_clean) |=> (mode_r == MODE_STOP) == $past(stop_req))
    else $error("undervoltage did not release");
  chk_ov_gates_off: assert property (
    ov_f |=> gate_o == '0)
    else $error("gates on during overvoltage");
  chk_ov_self_release: assert property (
    (ov_f ##1 s_supply_clean) |-> mode_nxt != MODE_STOP || stop_req)
    else $error("overvoltage did not release");
  chk_tsd_gates_off: assert property (
    ot_f |=> tsd_r ##1 gate_o == '0)
    else $error("thermal trip left gates on");
  chk_latch_holds: assert property (
    ((tsd_r || ocl_r) && !stop_req) |=> (tsd_r || ocl_r))
    else $error("latched shutdown left without stop");
  sequence s_oc_release;
    ocl_r && stop_req && !oc_trip;
  endsequence
  chk_latch_release: assert property (
    s_oc_release |=> !ocl_r)
    else $error("overcurrent latch not released");
  chk_oc_any_trips: assert property (
    (oc_f != '0 && oc_cnt_r == OC_TRIP) |=> ocl_r)
    else $error("single monitor did not trip");
  chk_oc_filter_time: assert property (
    $rose(ocl_r) |-> $past(oc_any) && $past(oc_cnt_r) == OC_TRIP)
    else $error("overcurrent tripped before filter");
  chk_fault_override: assert property (
    fault_any |=> gate_o == '0 [*1] ##0 mode_r == MODE_STOP)
    else $error("fault did not force stop");
  chk_dead_load: assert property (
    $rose(dt_cnt_r[0] != '0) |-> dt_cnt_r[0] == DT_LOAD)
    else $error("dead time not loaded from parameter");
endmodule : hbpc_top

// file: sim/hbpc_host_model.sv
// Host controller model that drives the two direction pins
`timescale 1ns/1ps

module hbpc_host_model #(
  parameter int unsigned HALF = 40
) (
  input  wire logic       sys_clk_i,
  input  wire logic [1:0] pins_i,
  input  wire logic       pwm_en_i,
  output logic            dir_in_a_o,
  output logic            dir_in_b_o
);
  int unsigned cnt = 0;
  logic        ph  = 1'h0;

  // Pins jump straight between modes; no off gap, the block owns dead time
  always @(posedge sys_clk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      ph <= ~ph;
    if (pwm_en_i && ph)
      {dir_in_a_o, dir_in_b_o} <= 2'h3;
    else
      {dir_in_a_o, dir_in_b_o} <= pins_i;
  end
endmodule // hbpc_host_model

// file: sim/test_hbpc_top.sv
// Self-checking bench for the bridge protection block
`timescale 1ns/1ps

module test_hbpc_top;
  import hbpc_pkg::*;
  localparam int unsigned DC = 2;
  localparam int unsigned OC = 4;

  logic              sys_clk_i   = 1'h0;
  logic              rst_b_i     = 1'h0;
  logic              uv_r        = 1'h0;
  logic              ov_r        = 1'h0;
  logic              ot_r        = 1'h0;
  logic [NUM_TR-1:0] oc_r        = '0;
  logic [ADDR_W-1:0] addr_r      = '0;
  logic [DATA_W-1:0] wdata_r     = '0;
  logic              wr_r        = 1'h0;
  logic              rd_r        = 1'h0;
  logic [1:0]        pins_r      = 2'h0;
  logic              pwm_r       = 1'h0;
  logic              dir_a;
  logic              dir_b;
  logic [DATA_W-1:0] rdata;
  hbpc_gates_t       gates;
  logic              irq;
  logic [1:0]        p;
  logic [7:0]        m;
  logic              bad;
  int                n;
  int                nf;
  int                nb;
  int                fail_count  = 0;
  int                checks_done = 0;

  // 250 MHz timebase
  always #2 sys_clk_i = ~sys_clk_i;

  hbpc_host_model #(.HALF(40)) i_hbpc_host_model (
    .sys_clk_i  (sys_clk_i),
    .pins_i     (pins_r),
    .pwm_en_i   (pwm_r),
    .dir_in_a_o (dir_a),
    .dir_in_b_o (dir_b)
  );

  hbpc_top #(.DEAD_CYC(DC), .OC_CYC(OC)) i_hbpc_top (
    .sys_clk_i      (sys_clk_i),
    .rst_b_i        (rst_b_i),
    .dir_in_a_i     (dir_a),
    .dir_in_b_i     (dir_b),
    .undervoltage_i (uv_r),
    .overvoltage_i  (ov_r),
    .overtemp_i     (ot_r),
    .overcurrent_i  (oc_r),
    .addr_i         (addr_r),
    .wdata_i        (wdata_r),
    .wr_i           (wr_r),
    .rd_i           (rd_r),
    .rdata_o        (rdata),
    .gate_o         (gates),
    .irq_o          (irq)
  );

  // Forward drives a high and b low; brake pulls both outputs low
  function automatic logic [3:0] exp_gates(logic [1:0] pv);
    case (pv)
      2'h2:    return 4'h9;
      2'h1:    return 4'h6;
      2'h3:    return 4'h5;
      default: return 4'h0;
    endcase
  endfunction

  task automatic stop_test();
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic report(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Look just after the edge so the flop outputs have settled
  task automatic cmp_gates(logic [3:0] exp);
    #1;
    report("gate_o", {4'h0, exp}, {4'h0, gates});
  endtask

  task automatic cmp_irq(logic exp);
    #1;
    report("irq_o", {7'h0, exp}, {7'h0, irq});
  endtask

  task automatic tick(int k);
    repeat (k) @(posedge sys_clk_i);
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge sys_clk_i);
    addr_r  <= a;
    wdata_r <= d;
    wr_r    <= 1'h1;
    @(posedge sys_clk_i);
    wr_r    <= 1'h0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic cmp_reg(logic [3:0] a, logic [7:0] exp);
    @(posedge sys_clk_i);
    addr_r <= a;
    rd_r   <= 1'h1;
    @(posedge sys_clk_i);
    rd_r   <= 1'h0;
    #1;
    report("rdata_o", exp, rdata);
  endtask

  // Long enough for sync, filter and dead time to settle
  task automatic go(logic [1:0] pv);
    @(posedge sys_clk_i);
    pins_r <= pv;
    tick(20);
  endtask

  // Watchdog sized well above the expected run of about 1400 cycles
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h52b12d64));
    tick(10);
    rst_b_i <= 1'h1;
    tick(8);
    cmp_gates(4'h0);
    cmp_irq(1'h0);
    cmp_reg(REG_MASK, 8'h00);
    cmp_reg(4'hc, 8'h00);
    wr(REG_FAULT, 8'hff);
    cmp_reg(REG_FAULT, 8'h00);
    // Every mode once, then random mode hopping with no gaps
    for (int i = 0; i < 16; i++) begin
      p = (i < 4) ? 2'(i) : 2'($urandom);
      go(p);
      cmp_gates(exp_gates(p));
    end
    // Reversal: count off cycles and watch for shoot-through
    go(2'h2);
    @(posedge sys_clk_i);
    pins_r <= 2'h1;
    n = 0;
    bad = 1'h0;
    repeat (20) begin
      @(posedge sys_clk_i);
      #1;
      if (gates === 4'h0)
        n++;
      bad = bad | (gates.a.hi & gates.a.lo) | (gates.b.hi & gates.b.lo);
    end
    report("dead_off", 8'(DC + 1), 8'(n));
    report("overlap", 8'h00, {7'h0, bad});
    // Host alternates drive and brake
    @(posedge sys_clk_i);
    pwm_r <= 1'h1;
    nf = 0;
    nb = 0;
    repeat (400) begin
      @(posedge sys_clk_i);
      #1;
      if (gates === 4'h6)
        nf++;
      if (gates === 4'h5)
        nb++;
    end
    report("pwm_mix", 8'h01, 8'((nf > 100) && (nb > 100)));
    @(posedge sys_clk_i);
    pwm_r <= 1'h0;
    // Supply faults with a random interrupt mask
    m = 8'($urandom);
    wr(REG_MASK, m);
    cmp_reg(REG_MASK, m & 8'h0f);
    go(2'h2);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk_i);
      if (k == 0)
        uv_r <= 1'h1;
      else
        ov_r <= 1'h1;
      tick(10);
      cmp_gates(4'h0);
      cmp_irq(m[k]);
      @(posedge sys_clk_i);
      uv_r <= 1'h0;
      ov_r <= 1'h0;
      tick(20);
      cmp_gates(4'h9);
      cmp_reg(REG_STATUS, 8'(1 << k));
      wr(REG_STATUS, 8'(1 << k));
      tick(3);
      cmp_reg(REG_STATUS, 8'h00);
      cmp_irq(1'h0);
    end
    // Thermal trip stays latched until both pins go low
    @(posedge sys_clk_i);
    ot_r <= 1'h1;
    tick(10);
    cmp_gates(4'h0);
    @(posedge sys_clk_i);
    ot_r <= 1'h0;
    tick(20);
    cmp_gates(4'h0);
    cmp_reg(REG_FAULT, 8'h04);
    cmp_irq(m[EV_TSD]);
    go(2'h0);
    go(2'h2);
    cmp_gates(4'h9);
    cmp_reg(REG_STATE, {MODE_FORWARD, 4'h9});
    wr(REG_STATUS, 8'h0f);
    // Each transistor monitor: short glitch ignored, long one trips
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk_i);
      oc_r[k] <= 1'h1;
      tick(2);
      oc_r <= '0;
      tick(20);
      cmp_gates(4'h9);
      @(posedge sys_clk_i);
      oc_r[k] <= 1'h1;
      tick(OC + 12);
      cmp_gates(4'h0);
      @(posedge sys_clk_i);
      oc_r <= '0;
      tick(20);
      cmp_gates(4'h0);
      cmp_reg(REG_STATUS, 8'h08);
      cmp_reg(REG_FAULT, 8'h08);
      cmp_irq(m[EV_OC]);
      wr(REG_STATUS, 8'h08);
      go(2'h0);
      go(2'h2);
      cmp_gates(4'h9);
    end
    stop_test();
  end
endmodule // test_hbpc_top
